// file: verilog/irq_monitor_pkg.sv
/*
  Shared constants and carriers for the interrupt monitor aggregator:
  register offsets, control field positions, reset values and counts.
  Assumes a 15-bit register address space reached over the serial port.
*/
package irq_monitor_pkg;

  // Register offsets.
  localparam logic [14:0] IRQ_CTRL_ADDR = 15'h005C;
  localparam logic [14:0] DRIFT_THRESHOLD_ADDR = 15'h005D;
  localparam logic [14:0] TEMP_CHANGE_THRESHOLD_ADDR = 15'h005E;
  localparam logic [14:0] CONV_CTRL_ADDR = 15'h0061;
  localparam logic [14:0] CONV_DIV_ADDR = 15'h0062;
  localparam logic [14:0] CONV_TRIGGER_ADDR = 15'h0072;
  localparam logic [14:0] BUSY_STATUS_ADDR = 15'h008F;
  localparam logic [14:0] MONITOR_STATUS_ADDR = 15'h0090;
  localparam logic [14:0] DRIFT_CHANNEL_FLAGS_UPPER_ADDR = 15'h0091;
  localparam logic [14:0] TEMP_MAGNITUDE_ADDR = 15'h0092;
  localparam logic [14:0] TEMP_SIGN_ADDR = 15'h0093;

  // Interrupt control register fields.
  localparam int IRQ_DRIVE_SELECT_BIT = 0;
  localparam int PLL_IRQ_ENABLE_BIT = 1;
  localparam int DRIFT_IRQ_ENABLE_BIT = 2;
  localparam int TEMP_IRQ_ENABLE_BIT = 3;
  localparam int CONVERTER_FAULT_IRQ_ENABLE_BIT = 4;
  localparam int TEMP_CHANGE_FLAG_CLEAR_BIT = 5;
  localparam int DRIFT_MON_HOLD_BIT = 6;
  localparam int OUTPUT_LEVEL_SELECT_BIT = 7;

  // Converter control register fields.
  localparam int CONV_ENABLE_BIT = 0;
  localparam int CONV_CLOCK_ENABLE_BIT = 1;
  localparam int CONV_TRIGGER_ENABLE_BIT = 2;
  localparam int CONV_CLOCK_SELECT_BIT = 6;
  localparam int CONVERTER_FAULT_MON_HOLD_BIT = 7;

  // Status register fields.
  localparam int BUSY_CONV_BIT = 1;
  localparam int STATUS_PLL_LOCK_BIT = 0;
  localparam int STATUS_TMP_ALIGN_BIT = 3;
  localparam int STATUS_TEMP_FLAG_BIT = 4;

  // Reset values.
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] CONV_DIV_RESET = 8'h00;

  // Channel count, accumulator width and conversion length.
  localparam int NUM_CHANNELS = 10;
  localparam int ACCUM_WIDTH = 12;
  localparam logic [4:0] CONV_CYCLES = 5'd17;

  // Serial frame: read flag, 15 address bits, 8 data bits.
  localparam logic [4:0] FRAME_ADDR_BITS = 5'd16;
  localparam logic [4:0] FRAME_BITS = 5'd24;

  // One alignment result from the alignment engine.
  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [7:0] delay;
  } align_event_s;

  // One finished temperature result from the code-to-temp stage.
  typedef struct packed {
    logic done;
    logic sign;
    logic [7:0] magnitude;
  } temp_result_s;

endpackage : irq_monitor_pkg

// file: verilog/irq_monitor_aggregator.sv
/*
  Interrupt monitor aggregator: serial register slave, temperature change
  monitor, per-channel drift accumulators, converter fault monitor,
  converter clock divider and the active-low interrupt pin driver.
  Assumes alignment, temperature and fault inputs come from logic on mclk,
  and the serial pins come from outside and are synchronised here.
*/
// Notes on behaviour
// - Bit 0 of 0x5C picks push-pull (0) or open-drain (1) interrupt pin.
// - Open-drain pulls pin low for level 0, releases it for level 1.
// - Mask bits gate sources onto the pin; masked monitors keep running.
// - Pin is the inverted OR of all enabled sources.
// - PLL lock source is live, unlatched, asserted while lock status is high.
// - First result after temperature clear toggle becomes the reference.
// - Later results exceeding threshold by absolute difference latch flag.
// - Each alignment adds cancelled delay to its channel accumulator.
// - Drift hold bit 1 stops monitoring; toggling restarts; clear after reset.
// - Channel flag sets above threshold; 9..2 in 0x91, 1..0 in 0x90[7:6].
// - Drift source reaches the pin only while 0x5C bit 2 is 1.
// - Rising OR of the two fault bits latches the converter fault flag.
// - Converter fault and temporary alignment share one line and enable.
// - Fault hold bit 1 stops monitoring; toggling restarts; clear after reset.
// - Converter clock is the source divided by four K plus two.
// - Result is magnitude in 0x92 and sign in 0x93 bit 0, 1 negative.
// - Shared fault line reaches the pin only while 0x5C bit 4 is 1.
`timescale 1ns/1ps
module irq_monitor_aggregator (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  input wire logic pll_lock_status,
  input wire logic [1:0] converter_fault_bits,
  input wire logic tmp_align_error,
  input wire irq_monitor_pkg::align_event_s align_event,
  input wire irq_monitor_pkg::temp_result_s temp_result,
  output logic conv_clock,
  output logic conv_start,
  output logic conv_enable,
  output logic output_level_select,
  output logic irq_out_n,
  output logic irq_out_n_oe_n
);

  localparam int NCH = irq_monitor_pkg::NUM_CHANNELS;
  localparam int AW = irq_monitor_pkg::ACCUM_WIDTH;

  // Serial pin synchronisers; only the second stage is read by logic.
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic sclk_prev_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= 3'h2;
      pin_sync_r <= 3'h2;
      sclk_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= {sclk, cs_n, sdi};
      pin_sync_r <= pin_meta_r;
      sclk_prev_r <= pin_sync_r[2];
    end
  end

  wire sclk_s = pin_sync_r[2];
  wire cs_n_s = pin_sync_r[1];
  wire sdi_s = pin_sync_r[0];
  wire sclk_rise = sclk_s && !sclk_prev_r;
  wire sclk_fall = !sclk_s && sclk_prev_r;

  // Serial frame state.
  logic [4:0] bit_cnt_r;
  logic [23:0] shift_in_r;
  logic [7:0] shift_out_r;

  // Register storage.
  logic [7:0] irq_ctrl_r;
  logic [7:0] drift_limit_r;
  logic [7:0] temp_change_limit_r;
  logic [7:0] conv_ctrl_r;
  logic [7:0] conv_div_r;
  logic conv_busy_r;
  logic [7:0] temp_mag_r;
  logic temp_sign_r;

  // Frame decode: the 24th bit is the one being sampled now.
  wire [23:0] frame_word = {shift_in_r[22:0], sdi_s};
  wire frame_active = !cs_n_s;
  wire bit_taken = frame_active && sclk_rise;
  wire addr_done = bit_taken && (bit_cnt_r == 5'(irq_monitor_pkg::FRAME_ADDR_BITS - 5'd1));
  wire frame_done = bit_taken && (bit_cnt_r == 5'(irq_monitor_pkg::FRAME_BITS - 5'd1));
  wire [14:0] hdr_addr = frame_word[14:0];
  wire frame_write = frame_done && !frame_word[23];
  wire [14:0] wr_addr = frame_word[22:8];
  wire [7:0] wr_data = frame_word[7:0];

  wire wr_irq_ctrl = frame_write && (wr_addr == irq_monitor_pkg::IRQ_CTRL_ADDR);
  wire wr_drift = frame_write && (wr_addr == irq_monitor_pkg::DRIFT_THRESHOLD_ADDR);
  wire wr_temp = frame_write && (wr_addr == irq_monitor_pkg::TEMP_CHANGE_THRESHOLD_ADDR);
  wire wr_conv_ctrl = frame_write && (wr_addr == irq_monitor_pkg::CONV_CTRL_ADDR);
  wire wr_conv_div = frame_write && (wr_addr == irq_monitor_pkg::CONV_DIV_ADDR);
  wire wr_trigger = frame_write && (wr_addr == irq_monitor_pkg::CONV_TRIGGER_ADDR);

  // Control fields.
  wire drive_open_drain = irq_ctrl_r[irq_monitor_pkg::IRQ_DRIVE_SELECT_BIT];
  wire pll_irq_en = irq_ctrl_r[irq_monitor_pkg::PLL_IRQ_ENABLE_BIT];
  wire drift_irq_en = irq_ctrl_r[irq_monitor_pkg::DRIFT_IRQ_ENABLE_BIT];
  wire temp_irq_en = irq_ctrl_r[irq_monitor_pkg::TEMP_IRQ_ENABLE_BIT];
  wire fault_irq_en = irq_ctrl_r[irq_monitor_pkg::CONVERTER_FAULT_IRQ_ENABLE_BIT];
  wire temp_change_flag_clear = irq_ctrl_r[irq_monitor_pkg::TEMP_CHANGE_FLAG_CLEAR_BIT];
  wire drift_mon_hold = irq_ctrl_r[irq_monitor_pkg::DRIFT_MON_HOLD_BIT];
  wire fault_mon_hold = conv_ctrl_r[irq_monitor_pkg::CONVERTER_FAULT_MON_HOLD_BIT];
  wire conv_clk_sel = conv_ctrl_r[irq_monitor_pkg::CONV_CLOCK_SELECT_BIT];
  wire conv_clk_en = conv_ctrl_r[irq_monitor_pkg::CONV_CLOCK_ENABLE_BIT];
  wire conv_trig_en = conv_ctrl_r[irq_monitor_pkg::CONV_TRIGGER_ENABLE_BIT];

  // Frame bit counter and input shifter; a raised select aborts the frame.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_r <= 5'h00;
      shift_in_r <= 24'h000000;
    end else if (!frame_active) begin
      bit_cnt_r <= 5'h00;
    end else if (bit_taken) begin
      shift_in_r <= frame_word;
      bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  // Writable registers.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ctrl_r <= irq_monitor_pkg::IRQ_CTRL_RESET;
      drift_limit_r <= irq_monitor_pkg::THRESHOLD_RESET;
      temp_change_limit_r <= irq_monitor_pkg::THRESHOLD_RESET;
      conv_ctrl_r <= irq_monitor_pkg::CONV_CTRL_RESET;
      conv_div_r <= irq_monitor_pkg::CONV_DIV_RESET;
    end else begin
      if (wr_irq_ctrl) irq_ctrl_r <= wr_data;
      if (wr_drift) drift_limit_r <= wr_data;
      if (wr_temp) temp_change_limit_r <= wr_data;
      if (wr_conv_ctrl) conv_ctrl_r <= wr_data;
      if (wr_conv_div) conv_div_r <= wr_data;
    end
  end

  // Converter clock source: every core cycle, or each serial clock rise.
  logic [9:0] div_cnt_r;
  logic conv_tick_r;
  logic [4:0] conv_cycle_r;
  wire src_tick = conv_clk_sel ? sclk_rise : 1'b1;
  wire [9:0] div_last = {conv_div_r, 2'b01};

  // Divider by 4K+2 producing a one-cycle converter clock enable.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= 10'h000;
      conv_tick_r <= 1'b0;
    end else begin
      conv_tick_r <= 1'b0;
      if (!conv_clk_en) begin
        div_cnt_r <= 10'h000;
      end else if (src_tick) begin
        conv_tick_r <= (div_cnt_r == div_last);
        div_cnt_r <= (div_cnt_r == div_last) ? 10'h000 : div_cnt_r + 10'h001;
      end
    end
  end

  // Conversion busy spans 17 converter clocks from the trigger write.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      conv_busy_r <= 1'b0;
      conv_cycle_r <= 5'h00;
      conv_start <= 1'b0;
    end else begin
      conv_start <= wr_trigger && conv_trig_en;
      if (wr_trigger && conv_trig_en) begin
        conv_busy_r <= 1'b1;
        conv_cycle_r <= 5'h00;
      end else if (conv_busy_r && conv_tick_r) begin
        conv_cycle_r <= conv_cycle_r + 5'h01;
        if (conv_cycle_r == irq_monitor_pkg::CONV_CYCLES - 5'd1) begin
          conv_busy_r <= 1'b0;
        end
      end
    end
  end

  // Stored temperature result, sign and magnitude.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      temp_mag_r <= 8'h00;
      temp_sign_r <= 1'b0;
    end else if (temp_result.done) begin
      temp_mag_r <= temp_result.magnitude;
      temp_sign_r <= temp_result.sign;
    end
  end

  // Temperature monitor arithmetic in ten-bit two's complement.
  logic ref_valid_r;
  logic [9:0] temp_ref_r;
  logic temp_change_flag;
  wire [9:0] temp_now = temp_result.sign ?
    10'(-{2'b00, temp_result.magnitude}) : {2'b00, temp_result.magnitude};
  wire [9:0] temp_delta = temp_now - temp_ref_r;
  wire [9:0] temp_abs = temp_delta[9] ? 10'(-temp_delta) : temp_delta;
  wire temp_exceeds = temp_abs > {2'b00, temp_change_limit_r};

  // Clear bit high discards the reference and flag; first result after is ref.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ref_valid_r <= 1'b0;
      temp_ref_r <= 10'h000;
      temp_change_flag <= 1'b0;
    end else if (temp_change_flag_clear) begin
      ref_valid_r <= 1'b0;
      temp_change_flag <= 1'b0;
    end else if (temp_result.done) begin
      if (!ref_valid_r) begin
        ref_valid_r <= 1'b1;
        temp_ref_r <= temp_now;
      end else if (temp_exceeds) begin
        temp_change_flag <= 1'b1;
      end
    end
  end

  // Per-channel drift accumulators, saturating, with sticky flags.
  logic [NCH-1:0] drift_channel_flags;
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_drift
      logic [AW-1:0] accum_r;
      wire hit = align_event.valid && (align_event.channel == 4'(ch));
      wire [AW:0] sum = {1'b0, accum_r} + {{(AW-7){1'b0}}, align_event.delay};
      wire [AW-1:0] sat = sum[AW] ? {AW{1'b1}} : sum[AW-1:0];
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          accum_r <= '0;
          drift_channel_flags[ch] <= 1'b0;
        end else if (drift_mon_hold) begin
          accum_r <= '0;
          drift_channel_flags[ch] <= 1'b0;
        end else if (hit) begin
          accum_r <= sat;
          if (sat > {{(AW-8){1'b0}}, drift_limit_r}) begin
            drift_channel_flags[ch] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Converter fault monitor: rising OR of fault bits latches the flag.
  logic fault_prev_r;
  logic fault_flag_r;
  wire fault_any = |converter_fault_bits;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault_prev_r <= 1'b0;
      fault_flag_r <= 1'b0;
    end else if (fault_mon_hold) begin
      fault_prev_r <= 1'b0;
      fault_flag_r <= 1'b0;
    end else begin
      fault_prev_r <= fault_any;
      if (fault_any && !fault_prev_r) fault_flag_r <= 1'b1;
    end
  end

  // Source gating and combination into one interrupt level.
  wire src_pll = pll_irq_en && pll_lock_status;
  wire src_temp = temp_irq_en && temp_change_flag;
  wire src_drift = drift_irq_en && (|drift_channel_flags);
  wire src_fault = fault_irq_en && (fault_flag_r || tmp_align_error);
  wire irq_any = src_pll || src_temp || src_drift || src_fault;

  // Pin driver registered on the core clock.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_out_n <= 1'b1;
      irq_out_n_oe_n <= 1'b0;
    end else begin
      irq_out_n <= drive_open_drain ? 1'b0 : !irq_any;
      irq_out_n_oe_n <= drive_open_drain && !irq_any;
    end
  end

  // Read mux for the register addressed by the frame header.
  wire [7:0] status_word = {drift_channel_flags[1:0], 1'b0, temp_change_flag,
    tmp_align_error, converter_fault_bits, pll_lock_status};
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    case (hdr_addr)
      irq_monitor_pkg::IRQ_CTRL_ADDR: rd_data = irq_ctrl_r;
      irq_monitor_pkg::DRIFT_THRESHOLD_ADDR: rd_data = drift_limit_r;
      irq_monitor_pkg::TEMP_CHANGE_THRESHOLD_ADDR: rd_data = temp_change_limit_r;
      irq_monitor_pkg::CONV_CTRL_ADDR: rd_data = conv_ctrl_r;
      irq_monitor_pkg::CONV_DIV_ADDR: rd_data = conv_div_r;
      irq_monitor_pkg::BUSY_STATUS_ADDR: rd_data = {6'h00, conv_busy_r, 1'b0};
      irq_monitor_pkg::MONITOR_STATUS_ADDR: rd_data = status_word;
      irq_monitor_pkg::DRIFT_CHANNEL_FLAGS_UPPER_ADDR:
        rd_data = drift_channel_flags[9:2];
      irq_monitor_pkg::TEMP_MAGNITUDE_ADDR: rd_data = temp_mag_r;
      irq_monitor_pkg::TEMP_SIGN_ADDR: rd_data = {7'h00, temp_sign_r};
      default: rd_data = 8'h00;
    endcase
  end

  // Read data shifts out MSB first on serial clock falls after the header.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_out_r <= 8'h00;
      sdo <= 1'b0;
    end else if (addr_done && frame_word[15]) begin
      shift_out_r <= rd_data;
    end else if (frame_active && sclk_fall) begin
      sdo <= shift_out_r[7];
      shift_out_r <= {shift_out_r[6:0], 1'b0};
    end
  end

  assign conv_clock = conv_tick_r;
  assign conv_enable = conv_ctrl_r[irq_monitor_pkg::CONV_ENABLE_BIT];
  assign output_level_select =
    irq_ctrl_r[irq_monitor_pkg::OUTPUT_LEVEL_SELECT_BIT];

endmodule : irq_monitor_aggregator

// file: verification/irq_monitor_monitor.sv
/*
  Checker for the interrupt monitor aggregator top ports.
  Assumes serial write frames of 24 bits, mode 0, as the host model sends.
*/
`timescale 1ns/1ps
module irq_monitor_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic pll_lock_status,
  input wire logic [1:0] converter_fault_bits,
  input wire logic tmp_align_error,
  input wire logic conv_clock,
  input wire logic conv_start,
  input wire logic irq_out_n,
  input wire logic irq_out_n_oe_n
);
  logic [23:0] shift_r;
  logic [4:0] bits_r;
  logic [7:0] ctrl_r;
  logic hold_r;
  logic [8:0] seen_r;
  logic [3:0] age_r;
  logic [3:0] age_nxt;
  logic [23:0] frame_nxt;
  logic wr_last;
  logic pin_low;
  logic settled;
  // Shadow decode of write frames, so masks are known at the ports.
  assign frame_nxt = {shift_r[22:0], sdi};
  assign wr_last = !cs_n && bits_r == 5'h17 && !frame_nxt[23];
  assign pin_low = !irq_out_n_oe_n && !irq_out_n;
  assign settled = age_r == 4'hF && seen_r == {hold_r, ctrl_r};
  assign age_nxt = (seen_r != {hold_r, ctrl_r}) ? 4'h0 :
                   (settled ? age_r : age_r + 4'h1);
  // Bit counter restarts whenever the select is dropped.
  always_ff @(posedge sclk or posedge cs_n or negedge rst_b) begin
    if (!rst_b || cs_n) bits_r <= 5'h00;
    else bits_r <= bits_r + 5'h01;
  end
  // Control shadows commit on the last bit of a write frame.
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= 24'h000000;
      ctrl_r <= 8'h00;
      hold_r <= 1'h0;
    end else begin
      shift_r <= frame_nxt;
      if (wr_last && frame_nxt[22:8] == irq_monitor_pkg::IRQ_CTRL_ADDR)
        ctrl_r <= frame_nxt[7:0];
      if (wr_last && frame_nxt[22:8] == irq_monitor_pkg::CONV_CTRL_ADDR)
        hold_r <= frame_nxt[7];
    end
  end
  // Age counts core cycles since either shadow last changed.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seen_r <= 9'h000;
      age_r <= 4'h0;
    end else begin
      seen_r <= {hold_r, ctrl_r};
      age_r <= age_nxt;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_never_drive_high: assert property (!(irq_out_n && irq_out_n_oe_n))
    else $error("interrupt pin released while value high");
  a_push_pull_mode: assert property (settled && !ctrl_r[0] |->
    !irq_out_n_oe_n) else $error("push-pull pin not driven");
  a_open_drain_mode: assert property (settled && ctrl_r[0] |->
    !irq_out_n) else $error("open-drain pin drives high");
  a_masked_quiet: assert property (settled && ctrl_r[4:1] == 4'h0 |->
    !pin_low) else $error("pin asserted with all sources masked");
  a_pll_live: assert property (settled && ctrl_r[4:1] == 4'h1 &&
    $stable(pll_lock_status) && $past(pll_lock_status, 2) == pll_lock_status
    |-> pin_low == pll_lock_status) else $error("pin not following lock");
  a_fault_edge: assert property (settled && ctrl_r[4] && !hold_r &&
    $rose(|converter_fault_bits) |-> ##[1:3] pin_low)
    else $error("fault edge did not assert pin");
  a_fault_held: assert property (settled && ctrl_r[4:1] == 4'h8 &&
    !hold_r && pin_low && !tmp_align_error && !$past(tmp_align_error) &&
    !$past(tmp_align_error, 2) |=> pin_low) else $error("fault flag lost");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_conv_clock_gap: assert property (conv_clock |=> !conv_clock)
    else $error("converter clock pulses adjacent");
  c_pll_asserted: cover property (ctrl_r[4:1] == 4'h1 && pin_low);
  c_fault_asserted: cover property (ctrl_r[4:1] == 4'h8 && pin_low);
  c_open_release: cover property (ctrl_r[0] && irq_out_n_oe_n);
endmodule : irq_monitor_monitor

// file: verification/serial_host.sv
/*
  Host model: serial register master on sclk, cs_n, sdi and sdo.
  Assumes the core clock for pacing; each sclk phase lasts 5 core cycles.
*/
`timescale 1ns/1ps
module serial_host (
  input wire logic mclk,
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  // Idle bus: clock low, select high.
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi = 1'h0;
  end
  // One frame: flag, address, data, MSB first; read data taken before rise.
  task automatic xfer(input logic rd, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(negedge mclk);
    cs_n = 1'h0;
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      repeat (5) @(negedge mclk);
      if (i < 8) q[i] = sdo;
      sclk = 1'h1;
      repeat (5) @(negedge mclk);
      sclk = 1'h0;
    end
    repeat (5) @(negedge mclk);
    cs_n = 1'h1;
    sdi = ~sdi; // Unselected data line must not look held.
  endtask : xfer
endmodule : serial_host

// file: verification/tb.sv
/*
  Self-checking bench for the interrupt monitor aggregator.
  Assumes the host model and checker files compile before this one.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] expect_q;
  } row_s;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic sclk, cs_n, sdi, sdo;
  logic pll_lock_status = 1'h0;
  logic [1:0] converter_fault_bits = 2'h0;
  logic tmp_align_error = 1'h0;
  irq_monitor_pkg::align_event_s align_event = '0;
  irq_monitor_pkg::temp_result_s temp_result = '0;
  logic conv_clock, conv_start, conv_enable, output_level_select;
  logic irq_out_n, irq_out_n_oe_n;
  wire irq_level = irq_out_n_oe_n ? 1'h1 : irq_out_n; // Pull-up when released.
  int err_count = 0;
  int samples_checked = 0;
  int starts = 0;
  int n;
  logic [7:0] q;
  row_s rows [4] = '{
    '{irq_monitor_pkg::DRIFT_CHANNEL_FLAGS_UPPER_ADDR, 8'hFF, 8'h00},
    '{15'h7FF0, 8'hAA, 8'h00},
    '{irq_monitor_pkg::TEMP_CHANGE_THRESHOLD_ADDR, 8'h05, 8'h05},
    '{irq_monitor_pkg::DRIFT_THRESHOLD_ADDR, 8'h10, 8'h10}};
  always #50 mclk = ~mclk;
  // Counts start pulses seen on the converter.
  always @(posedge mclk) if (conv_start === 1'h1) starts++;
  irq_monitor_aggregator u_dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .pll_lock_status(pll_lock_status),
    .converter_fault_bits(converter_fault_bits),
    .tmp_align_error(tmp_align_error), .align_event(align_event),
    .temp_result(temp_result), .conv_clock(conv_clock),
    .conv_start(conv_start), .conv_enable(conv_enable),
    .output_level_select(output_level_select), .irq_out_n(irq_out_n),
    .irq_out_n_oe_n(irq_out_n_oe_n));
  serial_host u_host (.mclk(mclk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] pin();
    return {7'h00, irq_level};
  endfunction : pin
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] unused_q;
    u_host.xfer(1'h0, a, d, unused_q);
  endtask : wr
  task automatic rd(input logic [14:0] a);
    u_host.xfer(1'h1, a, 8'h00, q);
  endtask : rd
  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask : settle
  task automatic align(input logic [3:0] ch, input logic [7:0] dl);
    align_event = {1'h1, ch, dl};
    @(negedge mclk);
    align_event = '0;
    settle();
  endtask : align
  task automatic temp(input logic s, input logic [7:0] m);
    temp_result = {1'h1, s, m};
    @(negedge mclk);
    temp_result = '0;
    settle();
  endtask : temp
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Watchdog sized well above the roughly 12000 cycles the tests need.
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    give_verdict();
  end
  // Main sequence: reset, register rows, then each monitor in turn.
  initial begin
    repeat (8) @(negedge mclk);
    rst_b = 1'h1;
    check("pin at reset", pin(), 8'h01);
    check("drive at reset", {7'h00, irq_out_n_oe_n}, 8'h00);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h40);
    wr(irq_monitor_pkg::CONV_CTRL_ADDR, 8'h80);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      check("register", q, rows[i].expect_q);
    end
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h02);
    pll_lock_status = 1'h1;
    settle();
    check("lock pin", pin(), 8'h00);
    rd(irq_monitor_pkg::MONITOR_STATUS_ADDR);
    check("lock bit", q & 8'h01, 8'h01);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h03);
    check("drain low", {7'h00, irq_out_n}, 8'h00);
    pll_lock_status = 1'h0;
    settle();
    check("drain release", {7'h00, irq_out_n_oe_n}, 8'h01);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h00);
    wr(irq_monitor_pkg::CONV_CTRL_ADDR, 8'h00);
    wr(irq_monitor_pkg::CONV_TRIGGER_ADDR, 8'h00);
    converter_fault_bits = 2'h1;
    settle();
    check("masked fault", pin(), 8'h01);
    converter_fault_bits = 2'h0;
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h10);
    check("flag kept while masked", pin(), 8'h00);
    for (int b = 1; b < 4; b++) begin
      wr(irq_monitor_pkg::CONV_CTRL_ADDR, 8'h80);
      wr(irq_monitor_pkg::CONV_CTRL_ADDR, 8'h00);
      check("fault cleared", pin(), 8'h01);
      repeat (3) settle();
      converter_fault_bits = b[1:0];
      settle();
      converter_fault_bits = 2'h0;
      rd(irq_monitor_pkg::MONITOR_STATUS_ADDR);
      check("fault latched", pin(), 8'h00);
    end
    wr(irq_monitor_pkg::CONV_CTRL_ADDR, 8'h80);
    tmp_align_error = 1'h1;
    settle();
    check("shared line", pin(), 8'h00);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h00);
    check("shared masked", pin(), 8'h01);
    tmp_align_error = 1'h0;
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h04);
    align(4'h0, 8'h10);
    check("drift at limit", pin(), 8'h01);
    align(4'h0, 8'h01);
    check("drift over", pin(), 8'h00);
    align(4'h9, 8'h11);
    rd(irq_monitor_pkg::MONITOR_STATUS_ADDR);
    check("low flags", q & 8'hC0, 8'h40);
    rd(irq_monitor_pkg::DRIFT_CHANNEL_FLAGS_UPPER_ADDR);
    check("high flags", q, 8'h80);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h44);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h8C);
    check("drift restarted", pin(), 8'h01);
    check("level select", {7'h00, output_level_select}, 8'h01);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h28);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h08);
    temp(1'h0, 8'h14);
    temp(1'h0, 8'h19);
    check("temp at limit", pin(), 8'h01);
    temp(1'h0, 8'h0E);
    check("temp over", pin(), 8'h00);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h28);
    wr(irq_monitor_pkg::IRQ_CTRL_ADDR, 8'h08);
    temp(1'h1, 8'h02);
    temp(1'h0, 8'h03);
    check("new reference", pin(), 8'h01);
    temp(1'h1, 8'h08);
    check("signed change", pin(), 8'h00);
    rd(irq_monitor_pkg::TEMP_MAGNITUDE_ADDR);
    check("magnitude", q, 8'h08);
    rd(irq_monitor_pkg::TEMP_SIGN_ADDR);
    check("sign", q & 8'h01, 8'h01);
    wr(irq_monitor_pkg::CONV_DIV_ADDR, 8'h01);
    wr(irq_monitor_pkg::CONV_CTRL_ADDR, 8'h07);
    check("enable out", {7'h00, conv_enable}, 8'h01);
    n = 0;
    while (conv_clock !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (conv_clock !== 1'h1 && n < 20);
    check("divider period", n[7:0], 8'h06);
    check("refused trigger", starts[7:0], 8'h00);
    wr(irq_monitor_pkg::CONV_CTRL_ADDR, 8'h47);
    wr(irq_monitor_pkg::CONV_TRIGGER_ADDR, 8'h00);
    n = 0;
    do begin
      rd(irq_monitor_pkg::BUSY_STATUS_ADDR);
      n++;
    end while (q[1] === 1'h1 && n < 10);
    check("busy reads", n[7:0], 8'h05);
    check("one start", starts[7:0], 8'h01);
    rst_b = 1'h0;
    settle();
    check("pin in reset", pin(), 8'h01);
    rst_b = 1'h1;
    rd(irq_monitor_pkg::IRQ_CTRL_ADDR);
    check("control after reset", q, 8'h00);
    check("pin after reset", pin(), 8'h01);
    give_verdict();
  end
endmodule : tb
bind irq_monitor_aggregator irq_monitor_monitor u_mon (.mclk(mclk),
  .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
  .pll_lock_status(pll_lock_status),
  .converter_fault_bits(converter_fault_bits),
  .tmp_align_error(tmp_align_error), .conv_clock(conv_clock),
  .conv_start(conv_start), .irq_out_n(irq_out_n),
  .irq_out_n_oe_n(irq_out_n_oe_n));
